// [src/pci_target_decode_and_power_state.sv]
// pci target decode, master command choice and function power state
`include "pci_front_params.svh"
`default_nettype none
module pci_target_decode_and_power_state
  import pci_front_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // target bus side
  input wire logic addrValid,
  input wire logic dataValid,
  input wire logic [31:0] adIn,
  input wire logic [3:0] commandByteEnableLines_n,
  input wire logic idsel,
  output logic claim,
  output logic [1:0] accessKind,
  output logic dataAck,
  output logic [31:0] readData,
  // master command request
  input wire logic masterReq,
  input wire logic masterWrite,
  input wire logic masterIo,
  input wire logic masterMultiple,
  input wire logic masterLine,
  input wire logic masterFullLine,
  output logic masterCmdValid,
  output logic [3:0] masterCmd,
  // power side effects
  output logic [1:0] powerState,
  output logic softReset,
  output logic scsiClockEnable,
  output logic pllEnable
);

  logic claim_reg;
  logic claim_next;
  access_type acc_reg;
  access_type acc_next;
  logic isWrite_reg;
  logic isWrite_next;
  logic [7:0] index_reg;
  logic dataAck_reg;
  logic [31:0] readData_reg;
  logic masterCmdValid_reg;
  logic [3:0] masterCmd_reg;
  logic [3:0] masterCmd_next;
  logic [7:0] command_reg;
  logic [23:0] ioBase_reg;
  logic [23:0] memBase_reg;
  logic [1:0] power_reg;
  power_mode_type mode_reg;
  logic softReset_reg;
  logic scsiClockEnable_reg;
  logic pllEnable_reg;
  logic [7:0] opRegs [0:127];

  logic [3:0] busCmd;
  logic dataWr;
  logic cfgLowWr;
  logic [7:0] laneAddr [0:3];
  logic [7:0] laneData [0:3];
  logic [3:0] laneWr;
  logic powerWrEn;
  logic [1:0] powerWrValue;
  logic enterD3;

  assign busCmd = commandByteEnableLines_n;

  // address phase decode; anything not listed is never claimed
  always_comb begin
    claim_next = 1'b0;
    acc_next = ACC_NONE;
    isWrite_next = 1'b0;
    unique case (busCmd)
      `CMD_CFG_READ, `CMD_CFG_WRITE: begin
        if (idsel && adIn[10:8] == 3'h0) begin
          claim_next = 1'b1;
          acc_next = ACC_CFG;
        end
        isWrite_next = (busCmd == `CMD_CFG_WRITE);
      end
      `CMD_IO_READ, `CMD_IO_WRITE: begin
        if (adIn[31:8] == ioBase_reg && command_reg[`BIT_CMD_IO_EN]) begin
          claim_next = 1'b1;
          acc_next = ACC_IO;
        end
        isWrite_next = (busCmd == `CMD_IO_WRITE);
      end
      `CMD_MEM_READ, `CMD_READ_MULTIPLE, `CMD_READ_LINE: begin
        if (adIn[31:8] == memBase_reg && command_reg[`BIT_CMD_MEM_EN]) begin
          claim_next = 1'b1;
          acc_next = ACC_MEM;
        end
        isWrite_next = 1'b0;
      end
      `CMD_MEM_WRITE, `CMD_WRITE_INVALIDATE: begin
        if (adIn[31:8] == memBase_reg && command_reg[`BIT_CMD_MEM_EN]) begin
          claim_next = 1'b1;
          acc_next = ACC_MEM;
        end
        isWrite_next = 1'b1;
      end
      default: begin
        // acknowledge, special, dual address and reserved codes pass by
        claim_next = 1'b0;
      end
    endcase
  end

  // claim lasts from the address phase through one data phase
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      claim_reg <= 1'b0;
      acc_reg <= ACC_NONE;
      isWrite_reg <= 1'b0;
      index_reg <= 8'h00;
    end else if (addrValid) begin
      claim_reg <= claim_next;
      acc_reg <= acc_next;
      isWrite_reg <= isWrite_next;
      index_reg <= {adIn[7:2], 2'h0};
    end else if (dataValid) begin
      claim_reg <= 1'b0;
      acc_reg <= ACC_NONE;
    end
  end

  // one byte lane per enable, active low on the bus
  assign dataWr = claim_reg && dataValid && isWrite_reg;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      laneAddr[i] = {index_reg[7:2], i[1:0]};
      laneData[i] = adIn[8*i +: 8];
      laneWr[i] = dataWr && !commandByteEnableLines_n[i];
    end
  end

  // lower configuration half holds system parameters
  assign cfgLowWr = (acc_reg == ACC_CFG) && !index_reg[7];

  // read one byte of whichever space the cycle claimed
  function automatic logic [7:0] readByte(input access_type acc, input logic [7:0] addr,
                                          input logic [7:0] cmdv, input logic [23:0] iob,
                                          input logic [23:0] memb, input logic [1:0] pwr,
                                          input logic [7:0] opv);
    logic [7:0] value;
    value = 8'h00;
    if (acc != ACC_CFG || addr[7]) begin
      value = opv;
    end else begin
      unique case (addr)
        `OFF_COMMAND: value = cmdv;
        `OFF_IO_BASE: value = `IO_SPACE_FLAG;
        `OFF_IO_BASE + 8'h01: value = iob[7:0];
        `OFF_IO_BASE + 8'h02: value = iob[15:8];
        `OFF_IO_BASE + 8'h03: value = iob[23:16];
        `OFF_MEM_BASE: value = `MEM_SPACE_FLAG;
        `OFF_MEM_BASE + 8'h01: value = memb[7:0];
        `OFF_MEM_BASE + 8'h02: value = memb[15:8];
        `OFF_MEM_BASE + 8'h03: value = memb[23:16];
        `OFF_POWER_CTL: value = {6'h00, pwr};
        default: value = 8'h00;
      endcase
    end
    return value;
  endfunction

  // read data and acknowledge one cycle after the data phase
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      readData_reg <= 32'h00000000;
      dataAck_reg <= 1'b0;
    end else begin
      dataAck_reg <= claim_reg && dataValid;
      if (claim_reg && dataValid && !isWrite_reg) begin
        for (int i = 0; i < 4; i++) begin
          // disabled lanes read back as zero
          readData_reg[8*i +: 8] <= commandByteEnableLines_n[i] ? 8'h00 :
            readByte(acc_reg, laneAddr[i], command_reg, ioBase_reg, memBase_reg,
                     power_reg, opRegs[laneAddr[i][6:0]]);
        end
      end
    end
  end

  // operating registers; bit seven of the index is dropped so both halves alias in io and memory space, while config reaches only the upper half
  always_ff @(posedge mclk) begin
    if (!reset_n || softReset_reg) begin
      for (int j = 0; j < 128; j++) begin
        opRegs[j] <= `RST_OP_BYTE;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (laneWr[i] && (acc_reg != ACC_CFG || laneAddr[i][7])) begin
          opRegs[laneAddr[i][6:0]] <= laneData[i];
        end
      end
    end
  end

  // base address registers; the low byte is fixed so the window is 256 bytes
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ioBase_reg <= `RST_BASE;
      memBase_reg <= `RST_BASE;
    end else if (cfgLowWr) begin
      // lane zero is the fixed flag byte, so the loop starts at lane one
      for (int i = 1; i < 4; i++) begin
        if (laneWr[i]) begin
          if (laneAddr[i][7:2] == 6'(`OFF_IO_BASE >> 2)) begin
            ioBase_reg[8*(i-1) +: 8] <= laneData[i];
          end
          if (laneAddr[i][7:2] == 6'(`OFF_MEM_BASE >> 2)) begin
            memBase_reg[8*(i-1) +: 8] <= laneData[i];
          end
        end
      end
    end
  end

  // power field write; the reserved codes leave the state as it is
  always_comb begin
    powerWrEn = 1'b0;
    powerWrValue = power_reg;
    for (int i = 0; i < 4; i++) begin
      if (cfgLowWr && laneWr[i] && laneAddr[i] == `OFF_POWER_CTL) begin
        if (laneData[i][1:0] == `PWR_D0 || laneData[i][1:0] == `PWR_D3) begin
          powerWrEn = 1'b1;
          powerWrValue = laneData[i][1:0];
        end
      end
    end
  end
  assign enterD3 = powerWrEn && powerWrValue == `PWR_D3 && power_reg != `PWR_D3;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      power_reg <= `PWR_D0;
      mode_reg <= PWR_FULL;
    end else if (powerWrEn) begin
      power_reg <= powerWrValue;
      mode_reg <= (powerWrValue == `PWR_D3) ? PWR_OFF : PWR_FULL;
    end
  end

  // command register; the power entry wins over a write in the same cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      command_reg <= `RST_COMMAND;
    end else if (enterD3) begin
      command_reg <= `RST_COMMAND;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cfgLowWr && laneWr[i] && laneAddr[i] == `OFF_COMMAND) begin
          command_reg <= laneData[i];
        end
      end
    end
  end

  // side effects follow the held state one cycle later
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      softReset_reg <= 1'b0;
      scsiClockEnable_reg <= 1'b1;
      pllEnable_reg <= 1'b1;
    end else begin
      softReset_reg <= (mode_reg == PWR_OFF);
      scsiClockEnable_reg <= (mode_reg == PWR_FULL);
      pllEnable_reg <= (mode_reg == PWR_FULL);
    end
  end

  // master command choice; only io and memory codes can come out
  always_comb begin
    if (masterIo) begin
      masterCmd_next = masterWrite ? `CMD_IO_WRITE : `CMD_IO_READ;
    end else if (masterWrite) begin
      if (masterFullLine && opRegs[`OFF_CHIP_TEST_THREE][`BIT_INVALIDATE_EN] &&
          command_reg[`BIT_CMD_INVALIDATE_EN]) begin
        masterCmd_next = `CMD_WRITE_INVALIDATE;
      end else begin
        masterCmd_next = `CMD_MEM_WRITE;
      end
    end else if (masterMultiple && opRegs[`OFF_DMA_BURST_MODE][`BIT_READ_MULTIPLE_EN]) begin
      masterCmd_next = `CMD_READ_MULTIPLE;
    end else if (masterLine && opRegs[`OFF_DMA_BURST_MODE][`BIT_READ_LINE_EN]) begin
      masterCmd_next = `CMD_READ_LINE;
    end else begin
      masterCmd_next = `CMD_MEM_READ;
    end
  end

  // a held soft reset blocks new master cycles
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      masterCmdValid_reg <= 1'b0;
      masterCmd_reg <= `CMD_MEM_READ;
    end else begin
      masterCmdValid_reg <= masterReq && !softReset_reg;
      if (masterReq && !softReset_reg) begin
        masterCmd_reg <= masterCmd_next;
      end
    end
  end

  assign claim = claim_reg;
  assign accessKind = acc_reg;
  assign dataAck = dataAck_reg;
  assign readData = readData_reg;
  assign masterCmdValid = masterCmdValid_reg;
  assign masterCmd = masterCmd_reg;
  assign powerState = power_reg;
  assign softReset = softReset_reg;
  assign scsiClockEnable = scsiClockEnable_reg;
  assign pllEnable = pllEnable_reg;

endmodule
`default_nettype wire

// [src/pci_front_params.svh]
// constants for the pci target decode and power state block
`ifndef PCI_FRONT_PARAMS_SVH
`define PCI_FRONT_PARAMS_SVH
`define CMD_IACK 4'h0
`define CMD_SPECIAL 4'h1
`define CMD_IO_READ 4'h2
`define CMD_IO_WRITE 4'h3
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define CMD_CFG_READ 4'hA
`define CMD_CFG_WRITE 4'hB
`define CMD_READ_MULTIPLE 4'hC
`define CMD_DUAL_ADDR 4'hD
`define CMD_READ_LINE 4'hE
`define CMD_WRITE_INVALIDATE 4'hF
`define OFF_COMMAND 8'h04
`define OFF_IO_BASE 8'h10
`define OFF_MEM_BASE 8'h14
`define OFF_POWER_CTL 8'h44
`define OFF_DMA_BURST_MODE 7'h38
`define OFF_CHIP_TEST_THREE 7'h1B
`define BIT_CMD_IO_EN 0
`define BIT_CMD_MEM_EN 1
`define BIT_CMD_INVALIDATE_EN 4
`define BIT_READ_MULTIPLE_EN 2
`define BIT_READ_LINE_EN 3
`define BIT_INVALIDATE_EN 0
`define PWR_D0 2'h0
`define PWR_D3 2'h3
`define RST_COMMAND 8'h00
`define RST_BASE 24'h000000
`define RST_OP_BYTE 8'h00
`define IO_SPACE_FLAG 8'h01
`define MEM_SPACE_FLAG 8'h00
`endif

// [src/pci_front_pkg.sv]
// types shared by the pci target decode and power state block
`default_nettype none
package pci_front_pkg;
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_CFG,
    ACC_IO,
    ACC_MEM
  } access_type;
  typedef enum logic {
    PWR_FULL,
    PWR_OFF
  } power_mode_type;
endpackage
`default_nettype wire

// [dv/pci_front_sva.sv]
// port assertions for the pci target decode and power state block
`default_nettype none
module pci_front_sva (
  // clock, reset and target bus
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic addrValid,
  input wire logic dataValid,
  input wire logic [31:0] adIn,
  input wire logic [3:0] commandByteEnableLines_n,
  input wire logic idsel,
  input wire logic claim,
  input wire logic [1:0] accessKind,
  input wire logic dataAck,
  // master and power
  input wire logic masterReq,
  input wire logic masterCmdValid,
  input wire logic [3:0] masterCmd,
  input wire logic [1:0] powerState,
  input wire logic softReset,
  input wire logic scsiClockEnable,
  input wire logic pllEnable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire [3:0] cmd = commandByteEnableLines_n;
  wire cfg = addrValid && cmd[3:1] == 3'h5;
  cfg_claim_a: assert property (
    cfg && idsel && adIn[10:8] == 3'h0 |=> claim && accessKind == 2'h1)
    else $error("config cycle not claimed");
  no_select_a: assert property (cfg && !idsel |=> !claim)
    else $error("config claimed without select");
  high_bits_a: assert property (cfg && adIn[10:8] != 3'h0 |=> !claim)
    else $error("config claimed with high bits set");
  io_kind_a: assert property (
    addrValid && cmd[3:1] == 3'h1 |=> !claim || accessKind == 2'h2)
    else $error("io cycle claimed with wrong kind");
  mem_kind_a: assert property (
    addrValid && cmd inside {4'h6, 4'h7, 4'hC, 4'hE, 4'hF} |=> !claim || accessKind == 2'h3)
    else $error("memory cycle claimed with wrong kind");
  bad_code_a: assert property (
    addrValid && cmd inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hD} |=> !claim)
    else $error("unsupported command claimed");
  ack_cause_a: assert property (dataAck |-> $past(dataValid) && $past(claim))
    else $error("data ack without data phase");
  master_code_a: assert property (
    masterCmdValid |-> masterCmd inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF})
    else $error("illegal master command");
  master_gate_a: assert property (
    masterCmdValid |-> $past(masterReq) && !$past(softReset))
    else $error("master command without request");
  d3_effects_a: assert property (
    powerState == 2'h3 |=> softReset && !scsiClockEnable && !pllEnable)
    else $error("low power effects missing");
  d0_effects_a: assert property (
    powerState == 2'h0 |=> !softReset && scsiClockEnable && pllEnable)
    else $error("full power not restored");
endmodule
bind pci_target_decode_and_power_state pci_front_sva pci_front_sva_i (.*);
`default_nettype wire

// [dv/host_bus_master.sv]
// bus master model: one address phase, then one data phase
`default_nettype none
module host_bus_master (
  // clock
  input wire logic mclk,
  // request lines
  output logic addrValid,
  output logic dataValid,
  output logic [31:0] adIn,
  output logic [3:0] commandByteEnableLines_n,
  output logic idsel,
  // answer lines
  input wire logic dataAck,
  input wire logic [31:0] readData
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addrValid = 1'b0;
    dataValid = 1'b0;
    idsel = 1'b0;
    adIn = 32'h0;
    commandByteEnableLines_n = 4'hF;
  end
  // released lines show the inverse so a stale value never passes
  task automatic xfer(input logic [3:0] c, input logic s, input logic [31:0] a,
                      input logic [3:0] be, input logic [31:0] d,
                      output logic ok, output logic [31:0] rd);
    @(negedge mclk);
    addrValid = 1'b1;
    idsel = s;
    adIn = a;
    commandByteEnableLines_n = c;
    @(negedge mclk);
    addrValid = 1'b0;
    idsel = 1'b0;
    dataValid = 1'b1;
    adIn = d;
    commandByteEnableLines_n = be;
    @(negedge mclk);
    dataValid = 1'b0;
    adIn = ~d;
    commandByteEnableLines_n = ~be;
    ok = dataAck;
    rd = readData;
  endtask
endmodule
`default_nettype wire

// [dv/tb.sv]
// testbench: decode, register, master command and power tests
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset_n, addrValid, dataValid, idsel, claim, dataAck, ok;
  logic [31:0] adIn, readData, rd;
  logic [3:0] commandByteEnableLines_n, masterCmd;
  logic [1:0] accessKind, powerState;
  logic masterReq, masterWrite, masterIo, masterMultiple, masterLine, masterFullLine;
  logic masterCmdValid, softReset, scsiClockEnable, pllEnable;
  int err_total, n_compared;
  localparam logic [31:0] IOB = 32'h12345600;
  localparam logic [31:0] MEMB = 32'hABCDEF00;
  localparam logic [15:0] CLAIMS = 16'hD0CC;
  pci_target_decode_and_power_state pci_target_decode_and_power_state_i (.*);
  host_bus_master host_bus_master_i (.*);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [3:0] c, input logic [31:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    host_bus_master_i.xfer(c, c[3:1] == 3'h5, a, be, d, ok, rd);
  endtask
  // packed as powerState, softReset, scsiClockEnable, pllEnable
  function automatic logic [31:0] pwr();
    return {27'h0, powerState, softReset, scsiClockEnable, pllEnable};
  endfunction
  task automatic mreq(input logic [4:0] f, input logic v, input logic [3:0] c);
    @(negedge mclk);
    {masterWrite, masterIo, masterMultiple, masterLine, masterFullLine} = f;
    masterReq = 1'b1;
    @(negedge mclk);
    masterReq = 1'b0;
    chk({31'h0, masterCmdValid}, {31'h0, v});
    if (v) chk({28'h0, masterCmd}, {28'h0, c});
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge mclk);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_sim;
  end
  initial begin
    err_total = 0;
    n_compared = 0;
    reset_n = 1'b0;
    masterReq = 1'b0;
    {masterWrite, masterIo, masterMultiple, masterLine, masterFullLine} = 5'h0;
    repeat (8) @(negedge mclk);
    reset_n = 1'b1;
    chk(pwr(), 32'h3);
    host_bus_master_i.xfer(4'hB, 1'b0, 32'h04, 4'h0, 32'h13, ok, rd);
    chk({31'h0, ok}, 32'h0);
    bus(4'hB, 32'h104, 4'h0, 32'h13);
    chk({31'h0, ok}, 32'h0);
    bus(4'hB, 32'h04, 4'h0, 32'h13);
    bus(4'hB, 32'h10, 4'h0, IOB);
    bus(4'hB, 32'h14, 4'h0, MEMB);
    bus(4'hA, 32'h04, 4'h0, 32'h0);
    chk(rd, 32'h13);
    bus(4'hA, 32'h10, 4'h0, 32'h0);
    chk(rd, IOB | 32'h1);
    bus(4'hA, 32'h14, 4'h0, 32'h0);
    chk(rd, MEMB);
    $display("test done: config");
    bus(4'h3, IOB | 32'h38, 4'hE, 32'hFFFFFF0C);
    bus(4'h7, MEMB | 32'h18, 4'h7, 32'h01FFFFFF);
    bus(4'h6, MEMB | 32'hB8, 4'h0, 32'h0);
    chk(rd, 32'hC);
    bus(4'hA, 32'hB8, 4'h0, 32'h0);
    chk(rd, 32'hC);
    bus(4'h2, IOB | 32'h18, 4'h7, 32'h0);
    chk(rd, 32'h01000000);
    bus(4'h6, MEMB ^ 32'h80000000, 4'h0, 32'h0);
    chk({31'h0, ok}, 32'h0);
    bus(4'h6, MEMB ^ 32'h100, 4'h0, 32'h0);
    chk({31'h0, ok}, 32'h0);
    for (int i = 0; i < 16; i++) begin
      if (i != 10 && i != 11) begin
        bus(4'(i), (i < 4) ? IOB : MEMB, 4'hF, 32'h0);
        chk({31'h0, ok}, {31'h0, CLAIMS[i]});
      end
    end
    bus(4'hF, MEMB | 32'h38, 4'hE, 32'h4);
    bus(4'hC, MEMB | 32'h38, 4'h0, 32'h0);
    chk(rd, 32'h4);
    $display("test done: decode");
    mreq(5'b01000, 1'b1, 4'h2);
    mreq(5'b11000, 1'b1, 4'h3);
    mreq(5'b00100, 1'b1, 4'hC);
    mreq(5'b00010, 1'b1, 4'h6);
    mreq(5'b10001, 1'b1, 4'hF);
    bus(4'h7, MEMB | 32'h18, 4'h7, 32'h0);
    mreq(5'b10001, 1'b1, 4'h7);
    bus(4'h7, MEMB | 32'h38, 4'hE, 32'h8);
    mreq(5'b00010, 1'b1, 4'hE);
    mreq(5'b00100, 1'b1, 4'h6);
    $display("test done: master");
    bus(4'hB, 32'h44, 4'hE, 32'h1);
    bus(4'hA, 32'h44, 4'h0, 32'h0);
    chk(rd, 32'h0);
    bus(4'hB, 32'h44, 4'hE, 32'h3);
    repeat (3) @(negedge mclk);
    chk(pwr(), 32'h1C);
    bus(4'hA, 32'h04, 4'h0, 32'h0);
    chk(rd, 32'h0);
    bus(4'hA, 32'hB8, 4'h0, 32'h0);
    chk(rd, 32'h0);
    mreq(5'b00000, 1'b0, 4'h0);
    bus(4'hB, 32'h44, 4'hE, 32'h0);
    repeat (3) @(negedge mclk);
    chk(pwr(), 32'h3);
    mreq(5'b01000, 1'b1, 4'h2);
    $display("test done: power");
    end_sim;
  end
endmodule
`default_nettype wire
